// file: rtl/tmsa_core.v
// Status, alarm and setup logic of a local plus remote temperature monitor
// Assumes an external converter with start/done handshake and a
// register port decoded from the two-wire pointer address
`timescale 1ns/100ps
`include "tmsa_regs.vh"

// Operation
// - Alarm mode: flags sticky; high-limit mode: open only
// - Read-only status at pointer 02h
// - Local and remote over/under flags
// - Open flag set on open remote junction
// - Alarm mode: any flag sets latch, pin low
// - Status read clears flags whose cause gone
// - Address read frees latch only when clean
// - Trip flags set above limit, self-clear
// - Overtemp pin low while either channel tripped
// - Trip release at limit minus hysteresis
// - High-limit mode: pin set by high limits only, released at limit minus hysteresis
// - Setup read 03h, write 09h, reset 00h
// - Alarm disable bit ignored in high-limit mode
// - Shutdown finishes current conversion then stops
// - One-shot write in shutdown starts one conversion
// - Range bit selects standard or extended range
// - Rate read 04h, write 0Ah, reset 08h
// - Rate code doubles rate per step up to 09h
// - Upper bound read 05h, write 0Bh, reset 55h
// - Lower bound read 06h, write 0Ch, reset 00h
// - Status layout busy down to local trip
module tmsa_core #(
  parameter [31:0] INTERVAL_MAX_CYC = `TMSA_INTERVAL_MAX_CYC
) (
  input wire clk_i,
  input wire nrst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire alert_addr_rd_i,
  input wire conv_done_i,
  input wire [7:0] local_temp_i,
  input wire [7:0] remote_temp_i,
  input wire remote_open_i,
  input wire [7:0] remote_upper_i,
  input wire [7:0] remote_lower_i,
  input wire [7:0] local_trip_lim_i,
  input wire [7:0] remote_trip_lim_i,
  input wire [7:0] trip_hyst_i,
  output reg conv_start_o,
  output reg range_ext_o,
  output reg alarm_pin_n_o,
  output reg alarm_pin_oe_o,
  output reg overtemp_out_n_o,
  output reg overtemp_oe_o
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] setup_ff;
  reg [3:0] rate_code_ff;
  reg [7:0] local_upper_bits_ff;
  reg [7:0] local_lower_bits_ff;
  reg busy_ff;
  reg oneshot_ff;
  reg [31:0] tmr_ff;
  reg local_over_flag_ff;
  reg local_under_flag_ff;
  reg remote_over_flag_ff;
  reg remote_under_flag_ff;
  reg open_flag_ff;
  reg remote_trip_flag_ff;
  reg local_trip_flag_ff;
  reg [4:0] cause_ff;
  reg high_trip_ff;
  reg alarm_latch_ff;

  wire alarm_pin_disable = setup_ff[`TMSA_SETUP_ALARM_DIS];
  wire shutdown_ctrl = setup_ff[`TMSA_SETUP_SHUTDOWN];
  wire pin_function_select = setup_ff[`TMSA_SETUP_PIN_FUNC];

  // ------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------
  wire wr_setup = reg_wr_i && (reg_addr_i == `TMSA_WR_SETUP);
  wire wr_rate = reg_wr_i && (reg_addr_i == `TMSA_WR_RATE);
  wire wr_upper = reg_wr_i && (reg_addr_i == `TMSA_WR_UPPER);
  wire wr_lower = reg_wr_i && (reg_addr_i == `TMSA_WR_LOWER);
  wire wr_oneshot = reg_wr_i && (reg_addr_i == `TMSA_WR_ONESHOT);
  wire rd_status = reg_rd_i && (reg_addr_i == `TMSA_RD_STATUS);

  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  // Standard and extended formats are both offset binary, so one
  // unsigned compare serves either range setting.
  wire [8:0] loc_rel = {1'b0, local_trip_lim_i} - {1'b0, trip_hyst_i};
  wire [8:0] rem_rel = {1'b0, remote_trip_lim_i} - {1'b0, trip_hyst_i};
  wire [8:0] lup_rel = {1'b0, local_upper_bits_ff} - {1'b0, trip_hyst_i};
  wire [8:0] rup_rel = {1'b0, remote_upper_i} - {1'b0, trip_hyst_i};
  wire [79:0] cmp_meas;
  wire [79:0] cmp_bound;
  wire [9:0] cmp_above;
  wire [9:0] cmp_below;

  assign cmp_meas = {remote_temp_i, local_temp_i, remote_temp_i, local_temp_i,
                     remote_temp_i, local_temp_i, remote_temp_i, local_temp_i,
                     remote_temp_i, local_temp_i};
  assign cmp_bound = {rup_rel[7:0], lup_rel[7:0], rem_rel[7:0], loc_rel[7:0],
                      remote_trip_lim_i, local_trip_lim_i, remote_lower_i,
                      local_lower_bits_ff, remote_upper_i, local_upper_bits_ff};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_cmp
      tmsa_cmp #(
        .W(8)
      ) u_cmp (
        .meas_i(cmp_meas[8*gi+7:8*gi]),
        .bound_i(cmp_bound[8*gi+7:8*gi]),
        .above_o(cmp_above[gi]),
        .below_o(cmp_below[gi])
      );
    end
  endgenerate

  wire loc_over = cmp_above[0];
  wire rem_over = cmp_above[1];
  wire loc_under = cmp_below[2];
  wire rem_under = cmp_below[3];
  wire loc_trip_set = cmp_above[4];
  wire rem_trip_set = cmp_above[5];
  // A bound minus hysteresis below zero is never reached
  wire loc_trip_clr = ~cmp_above[6] & ~loc_rel[8];
  wire rem_trip_clr = ~cmp_above[7] & ~rem_rel[8];
  wire hi_release = ~cmp_above[8] & ~lup_rel[8] & ~cmp_above[9] & ~rup_rel[8];

  // ------------------------------------------------------------
  // Conversion scheduling
  // ------------------------------------------------------------
  wire [3:0] rate_eff = (rate_code_ff > `TMSA_RATE_MAX) ? `TMSA_RATE_MAX : rate_code_ff;
  // Interval is counted start to start, so the rate only stretches idle
  wire [31:0] interval_cyc = INTERVAL_MAX_CYC >> rate_eff;
  wire period_up = (tmr_ff >= interval_cyc - 32'h0000_0001);
  wire run_start = ~busy_ff && ~shutdown_ctrl && period_up;
  wire shot_start = ~busy_ff && shutdown_ctrl && (oneshot_ff || wr_oneshot);
  wire start = run_start || shot_start;
  wire done = busy_ff && conv_done_i;
  reg nxt_oneshot;

  always @* begin
    nxt_oneshot = oneshot_ff;
    if (wr_oneshot && shutdown_ctrl) begin
      nxt_oneshot = 1'b1;
    end
    if (shot_start || ~shutdown_ctrl) begin
      nxt_oneshot = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_ff <= 1'b0;
      oneshot_ff <= 1'b0;
      tmr_ff <= 32'hffff_ffff;
      conv_start_o <= 1'b0;
    end else begin
      oneshot_ff <= nxt_oneshot;
      conv_start_o <= start;
      if (start) begin
        busy_ff <= 1'b1;
        tmr_ff <= 32'h0000_0000;
      end else begin
        if (done) begin
          busy_ff <= 1'b0;
        end
        if (tmr_ff != 32'hffff_ffff) begin
          tmr_ff <= tmr_ff + 32'h0000_0001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Setup registers
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      setup_ff <= `TMSA_SETUP_RST;
      rate_code_ff <= `TMSA_RATE_RST;
      local_upper_bits_ff <= `TMSA_UPPER_RST;
      local_lower_bits_ff <= `TMSA_LOWER_RST;
      range_ext_o <= 1'b0;
    end else begin
      if (wr_setup) begin
        // Reserved bits are not stored and read back as zero
        setup_ff <= reg_wdata_i & 8'he4;
      end
      if (wr_rate) begin
        rate_code_ff <= reg_wdata_i[3:0];
      end
      if (wr_upper) begin
        local_upper_bits_ff <= reg_wdata_i;
      end
      if (wr_lower) begin
        local_lower_bits_ff <= reg_wdata_i;
      end
      range_ext_o <= setup_ff[`TMSA_SETUP_RANGE];
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // cause_ff keeps the last conversion's conditions: over, under, open
  reg nxt_lo;
  reg nxt_lu;
  reg nxt_ro;
  reg nxt_ru;
  reg nxt_op;
  reg nxt_lt;
  reg nxt_rt;
  reg [4:0] nxt_cause;
  reg [4:0] cur_cause;
  reg [4:0] ev;
  reg sticky;

  always @* begin
    nxt_cause = cause_ff;
    ev = 5'b00000;
    nxt_lt = local_trip_flag_ff;
    nxt_rt = remote_trip_flag_ff;
    sticky = ~pin_function_select;
    if (done) begin
      nxt_cause = {loc_over, loc_under, rem_over, rem_under, remote_open_i};
      ev = nxt_cause;
      if (loc_trip_set) begin
        nxt_lt = 1'b1;
      end else if (loc_trip_clr) begin
        nxt_lt = 1'b0;
      end
      if (rem_trip_set) begin
        nxt_rt = 1'b1;
      end else if (rem_trip_clr) begin
        nxt_rt = 1'b0;
      end
    end
    cur_cause = nxt_cause;
    // Set wins over a same-cycle clearing read
    nxt_lo = ev[4] | (sticky ? (local_over_flag_ff & ~(rd_status & ~cur_cause[4])) : cur_cause[4]);
    nxt_lu = ev[3] | (sticky ? (local_under_flag_ff & ~(rd_status & ~cur_cause[3])) : cur_cause[3]);
    nxt_ro = ev[2] | (sticky ? (remote_over_flag_ff & ~(rd_status & ~cur_cause[2])) : cur_cause[2]);
    nxt_ru = ev[1] | (sticky ? (remote_under_flag_ff & ~(rd_status & ~cur_cause[1])) : cur_cause[1]);
    nxt_op = ev[0] | (open_flag_ff & ~(rd_status & ~cur_cause[0]));
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      local_over_flag_ff <= 1'b0;
      local_under_flag_ff <= 1'b0;
      remote_over_flag_ff <= 1'b0;
      remote_under_flag_ff <= 1'b0;
      open_flag_ff <= 1'b0;
      local_trip_flag_ff <= 1'b0;
      remote_trip_flag_ff <= 1'b0;
      cause_ff <= 5'b00000;
    end else begin
      local_over_flag_ff <= nxt_lo;
      local_under_flag_ff <= nxt_lu;
      remote_over_flag_ff <= nxt_ro;
      remote_under_flag_ff <= nxt_ru;
      open_flag_ff <= nxt_op;
      local_trip_flag_ff <= nxt_lt;
      remote_trip_flag_ff <= nxt_rt;
      cause_ff <= nxt_cause;
    end
  end

  // ------------------------------------------------------------
  // Alarm latch and pins
  // ------------------------------------------------------------
  wire any_flag = local_over_flag_ff | local_under_flag_ff | remote_over_flag_ff |
                  remote_under_flag_ff | open_flag_ff;
  reg nxt_alarm;
  reg nxt_high;

  always @* begin
    nxt_alarm = alarm_latch_ff;
    // Status read alone never frees the latch
    if (alert_addr_rd_i && ~any_flag && (cause_ff == 5'b00000)) begin
      nxt_alarm = 1'b0;
    end
    if (any_flag && ~pin_function_select) begin
      nxt_alarm = 1'b1;
    end
    if (pin_function_select) begin
      nxt_alarm = 1'b0;
    end
    nxt_high = high_trip_ff;
    if (done) begin
      if (loc_over || rem_over) begin
        nxt_high = 1'b1;
      end else if (hi_release) begin
        nxt_high = 1'b0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      alarm_latch_ff <= 1'b0;
      high_trip_ff <= 1'b0;
      alarm_pin_n_o <= 1'b0;
      alarm_pin_oe_o <= 1'b0;
      overtemp_out_n_o <= 1'b0;
      overtemp_oe_o <= 1'b0;
    end else begin
      alarm_latch_ff <= nxt_alarm;
      high_trip_ff <= nxt_high;
      // Open drain: data stays low, enable pulls the line
      alarm_pin_n_o <= 1'b0;
      overtemp_out_n_o <= 1'b0;
      if (pin_function_select) begin
        alarm_pin_oe_o <= nxt_high;
      end else begin
        alarm_pin_oe_o <= nxt_alarm & ~alarm_pin_disable;
      end
      overtemp_oe_o <= nxt_lt | nxt_rt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  wire [7:0] status_byte = {busy_ff, local_over_flag_ff, local_under_flag_ff, remote_over_flag_ff,
                            remote_under_flag_ff, open_flag_ff, remote_trip_flag_ff,
                            local_trip_flag_ff};

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `TMSA_RDATA_IDLE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TMSA_RD_STATUS: begin
          reg_rdata_o <= status_byte;
        end
        `TMSA_RD_SETUP: begin
          reg_rdata_o <= setup_ff;
        end
        `TMSA_RD_RATE: begin
          reg_rdata_o <= {4'h0, rate_code_ff};
        end
        `TMSA_RD_UPPER: begin
          reg_rdata_o <= local_upper_bits_ff;
        end
        `TMSA_RD_LOWER: begin
          reg_rdata_o <= local_lower_bits_ff;
        end
        default: begin
          reg_rdata_o <= `TMSA_RDATA_IDLE;
        end
      endcase
    end
  end

endmodule // tmsa_core

// file: shared/tmsa_regs.vh
// Register offsets, field positions, reset values and timing counts
// Assumes a 20 MHz system clock and byte-wide pointer addresses
`ifndef TMSA_REGS_VH
`define TMSA_REGS_VH

// ------------------------------------------------------------
// Pointer addresses
// ------------------------------------------------------------
`define TMSA_RD_STATUS 8'h02
`define TMSA_RD_SETUP 8'h03
`define TMSA_RD_RATE 8'h04
`define TMSA_RD_UPPER 8'h05
`define TMSA_RD_LOWER 8'h06
`define TMSA_WR_SETUP 8'h09
`define TMSA_WR_RATE 8'h0a
`define TMSA_WR_UPPER 8'h0b
`define TMSA_WR_LOWER 8'h0c
`define TMSA_WR_ONESHOT 8'h0f

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TMSA_SETUP_RST 8'h00
`define TMSA_RATE_RST 4'h8
`define TMSA_UPPER_RST 8'h55
`define TMSA_LOWER_RST 8'h00
`define TMSA_RDATA_IDLE 8'h00

// ------------------------------------------------------------
// Setup fields
// ------------------------------------------------------------
`define TMSA_SETUP_ALARM_DIS 7
`define TMSA_SETUP_SHUTDOWN 6
`define TMSA_SETUP_PIN_FUNC 5
`define TMSA_SETUP_RANGE 2

// ------------------------------------------------------------
// Status fields
// ------------------------------------------------------------
`define TMSA_ST_BUSY 7
`define TMSA_ST_LOC_OVER 6
`define TMSA_ST_LOC_UNDER 5
`define TMSA_ST_REM_OVER 4
`define TMSA_ST_REM_UNDER 3
`define TMSA_ST_OPEN 2
`define TMSA_ST_REM_TRIP 1
`define TMSA_ST_LOC_TRIP 0

// ------------------------------------------------------------
// Conversion timing
// ------------------------------------------------------------
`define TMSA_RATE_MAX 4'h9
`define TMSA_INTERVAL_S 16
`define TMSA_CLK_HZ 20000000
`define TMSA_INTERVAL_MAX_CYC (`TMSA_INTERVAL_S * `TMSA_CLK_HZ)

`endif

// file: rtl/tmsa_cmp.v
// Unsigned magnitude comparator for one measurement against one bound
// Assumes both operands share the same binary format
`timescale 1ns/100ps
module tmsa_cmp #(
  parameter W = 8
) (
  input wire [W-1:0] meas_i,
  input wire [W-1:0] bound_i,
  output wire above_o,
  output wire below_o
);

  assign above_o = (meas_i > bound_i);
  assign below_o = (meas_i < bound_i);

endmodule // tmsa_cmp

// file: verification/tmsa_core_checker.sv
// Concurrent checks on the status, alarm and setup block
// Assumes it is bound to tmsa_core and sees only that module's ports
`timescale 1ns/100ps
module tmsa_core_checker #(
  parameter [31:0] INTERVAL_MAX_CYC = 32'd1024
) (
  input wire clk_i,
  input wire nrst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire alert_addr_rd_i,
  input wire conv_done_i,
  input wire conv_start_o,
  input wire range_ext_o,
  input wire alarm_pin_n_o,
  input wire alarm_pin_oe_o,
  input wire overtemp_out_n_o,
  input wire overtemp_oe_o
);
  // --------------------------------------------------
  // Shutdown state seen from setup writes
  // --------------------------------------------------
  reg shut_ff;
  wire nxt_shut = (reg_wr_i && reg_addr_i == 8'h09) ? reg_wdata_i[6] : shut_ff;
  always @(posedge clk_i) begin
    shut_ff <= nrst_i ? nxt_shut : 1'b0;
  end
  // --------------------------------------------------
  // Properties
  // --------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_unmapped;
    reg_rd_i && (reg_addr_i < 8'h02 || reg_addr_i > 8'h06) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reserved;
    reg_rd_i && reg_addr_i == 8'h03 |=> (reg_rdata_o & 8'h1b) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved setup bits read one");
  property p_open_drain;
    alarm_pin_n_o == 1'b0 && overtemp_out_n_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain data not low");
  property p_start_pulse;
    conv_start_o |=> !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_trip_cause;
    $changed(overtemp_oe_o) |-> $past(conv_done_i);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("overtemp moved without conversion");
  property p_alarm_fall;
    $fell(alarm_pin_oe_o) |-> $past(alert_addr_rd_i || conv_done_i) || $past(reg_wr_i) || $past(reg_wr_i, 2);
  endproperty
  a_alarm_fall: assert property (p_alarm_fall) else $error("alarm released without cause");
  property p_alarm_rise;
    $rose(alarm_pin_oe_o) |-> $past(conv_done_i) || $past(conv_done_i, 2) || $past(reg_wr_i) || $past(reg_wr_i, 2);
  endproperty
  a_alarm_rise: assert property (p_alarm_rise) else $error("alarm raised without cause");
  property p_range;
    reg_wr_i && reg_addr_i == 8'h09 |-> ##2 range_ext_o == $past(reg_wdata_i[2], 2);
  endproperty
  a_range: assert property (p_range) else $error("range output wrong");
  property p_oneshot;
    reg_wr_i && reg_addr_i == 8'h0f && shut_ff |-> ##[1:300] conv_start_o;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not start");
  c_alarm: cover property ($rose(alarm_pin_oe_o));
  c_trip: cover property ($rose(overtemp_oe_o));
  c_oneshot: cover property (reg_wr_i && reg_addr_i == 8'h0f && shut_ff);
endmodule // tmsa_core_checker

bind tmsa_core tmsa_core_checker #(.INTERVAL_MAX_CYC(INTERVAL_MAX_CYC)) chk_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .alert_addr_rd_i(alert_addr_rd_i),
  .conv_done_i(conv_done_i), .conv_start_o(conv_start_o), .range_ext_o(range_ext_o),
  .alarm_pin_n_o(alarm_pin_n_o), .alarm_pin_oe_o(alarm_pin_oe_o),
  .overtemp_out_n_o(overtemp_out_n_o), .overtemp_oe_o(overtemp_oe_o)
);

// file: verification/tmsa_conv_model.sv
// Converter model: answers each start with one done pulse and results
// Assumes starts never overlap a conversion in flight
`timescale 1ns/100ps
module tmsa_conv_model #(
  parameter LAT = 2
) (
  input wire clk_i,
  input wire conv_start_i,
  input wire [7:0] lt_i,
  input wire [7:0] rt_i,
  input wire open_i,
  output reg conv_done_o,
  output wire [7:0] local_temp_o,
  output wire [7:0] remote_temp_o,
  output wire remote_open_o
);
  integer cnt = 0;
  initial conv_done_o = 1'b0;
  always @(posedge clk_i) begin
    conv_done_o <= (cnt == 1);
    if (conv_start_i)
      cnt <= LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Results are valid only with done; inverted elsewhere so a stray sample shows
  assign local_temp_o = conv_done_o ? lt_i : ~lt_i;
  assign remote_temp_o = conv_done_o ? rt_i : ~rt_i;
  assign remote_open_o = conv_done_o ? open_i : ~open_i;
endmodule // tmsa_conv_model

// file: verification/test_temp_monitor_status_alert_cfg.sv
// Self-checking bench for the status, alarm and setup block
// Assumes tmsa_core, the converter model and the bound checker
`timescale 1ns/100ps
module test_temp_monitor_status_alert_cfg;
  localparam [31:0] IMAX = 32'd1024;
  // Flag cases {local, remote, open, expected flags}
  localparam [124:0] CASES = {8'h20, 8'h30, 1'b0, 8'h20, 8'h30, 8'h30, 1'b1, 8'h04,
    8'h30, 8'h08, 1'b0, 8'h08, 8'h30, 8'h58, 1'b0, 8'h10, 8'h60, 8'h30, 1'b0, 8'h40};
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg reg_wr_i = 1'b0, reg_rd_i = 1'b0, alert_addr_rd_i = 1'b0, op = 1'b0, o1;
  reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, lt = 8'h30, rt = 8'h30, d, e, q;
  // Trip limit and hysteresis are bench registers so the release point can move
  reg [7:0] hy = 8'h05, tl = 8'h64;
  reg [31:0] rs = 32'd31338;
  wire conv_done_i, remote_open_i, conv_start_o, range_ext_o;
  wire alarm_pin_n_o, alarm_pin_oe_o, overtemp_out_n_o, overtemp_oe_o;
  wire [7:0] local_temp_i, remote_temp_i, reg_rdata_o;
  // Open-drain lines with pull-up
  wire al = alarm_pin_oe_o ? alarm_pin_n_o : 1'b1;
  wire ot = overtemp_oe_o ? overtemp_out_n_o : 1'b1;
  integer miscompares = 0, checked = 0, cyc = 0, nst = 0, i, c, x;
  tmsa_core #(.INTERVAL_MAX_CYC(IMAX)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .alert_addr_rd_i(alert_addr_rd_i),
    .conv_done_i(conv_done_i), .local_temp_i(local_temp_i), .remote_temp_i(remote_temp_i),
    .remote_open_i(remote_open_i), .remote_upper_i(8'h50), .remote_lower_i(8'h10),
    .local_trip_lim_i(tl), .remote_trip_lim_i(8'h64), .trip_hyst_i(hy),
    .conv_start_o(conv_start_o), .range_ext_o(range_ext_o), .alarm_pin_n_o(alarm_pin_n_o),
    .alarm_pin_oe_o(alarm_pin_oe_o), .overtemp_out_n_o(overtemp_out_n_o), .overtemp_oe_o(overtemp_oe_o));
  tmsa_conv_model #(.LAT(2)) cm_u (
    .clk_i(clk_i), .conv_start_i(conv_start_o), .lt_i(lt), .rt_i(rt), .open_i(op),
    .conv_done_o(conv_done_i), .local_temp_o(local_temp_i), .remote_temp_o(remote_temp_i),
    .remote_open_o(remote_open_i));
  // --------------------------------------------------
  // Clock, start counter, timeout
  // --------------------------------------------------
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (conv_start_o === 1'b1) nst <= nst + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      results;
    end
  end
  // --------------------------------------------------
  // Tasks
  // --------------------------------------------------
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input string nm, input [7:0] ex, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== ex) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rdc(input string nm, input [7:0] a, input [7:0] m, input [7:0] ex);
    begin
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk(nm, ex, reg_rdata_o & m);
    end
  endtask
  task ack;
    begin
      @(posedge clk_i);
      alert_addr_rd_i <= 1'b1;
      @(posedge clk_i);
      alert_addr_rd_i <= 1'b0;
      @(negedge clk_i);
    end
  endtask
  // Apply temperatures, then let two conversions land
  task ap(input [7:0] l, input [7:0] r, input o);
    integer n;
    begin
      n = 2;
      @(posedge clk_i);
      lt <= l;
      rt <= r;
      op <= o;
      while (n > 0) begin
        @(posedge clk_i);
        if (conv_done_i === 1'b1) n = n - 1;
      end
      @(negedge clk_i);
    end
  endtask
  task cnt(input integer n);
    begin
      c = nst;
      repeat (n) @(negedge clk_i);
      c = nst - c;
    end
  endtask
  task results;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (i = 1; i < 8; i = i + 1)
      rdc("reset", i[7:0], (i == 2) ? 8'h7f : 8'hff, (i == 4) ? 8'h08 : (i == 5) ? 8'h55 : 8'h00);
    wr(8'h0c, 8'h28);
    for (i = 0; i < 5; i = i + 1) begin
      {d, q, o1, e} = CASES[i*25 +: 25];
      ap(d, q, o1);
      chk("alarm", 8'h00, al);
      rdc("flags", 8'h02, 8'h7f, e);
      ack;
      chk("heldack", 8'h00, al);
      ap(8'h30, 8'h30, 1'b0);
      rdc("sticky", 8'h02, 8'h7f, e);
      rdc("clear", 8'h02, 8'h7f, 8'h00);
      chk("latch", 8'h00, al);
      ack;
      chk("release", 8'h01, al);
    end
    wr(8'h09, 8'h80);
    ap(8'h60, 8'h30, 1'b0);
    chk("masked", 8'h01, al);
    wr(8'h09, 8'ha0);
    ap(8'h60, 8'h30, 1'b0);
    chk("hlmode", 8'h00, al);
    ap(8'h20, 8'h30, 1'b0);
    chk("hlrel", 8'h01, al);
    wr(8'h09, 8'h00);
    ap(8'h30, 8'h30, 1'b0);
    rdc("drain", 8'h02, 8'h7f, 8'h20);
    rdc("drain", 8'h02, 8'h7f, 8'h00);
    ack;
    chk("back", 8'h01, al);
    ap(8'h70, 8'h30, 1'b0);
    chk("trip", 8'h00, ot);
    rdc("tripst", 8'h02, 8'h7f, 8'h41);
    ap(8'h62, 8'h30, 1'b0);
    chk("hyst", 8'h00, ot);
    ap(8'h5f, 8'h30, 1'b0);
    chk("tripoff", 8'h01, ot);
    rdc("tripclr", 8'h02, 8'h7f, 8'h40);
    ap(8'h30, 8'h70, 1'b0);
    chk("rtrip", 8'h00, ot);
    ap(8'h30, 8'h30, 1'b0);
    chk("rtripoff", 8'h01, ot);
    @(posedge clk_i);
    hy <= 8'h00;
    tl <= 8'h68;
    ap(8'h70, 8'h30, 1'b0);
    chk("trip2", 8'h00, ot);
    ap(8'h65, 8'h30, 1'b0);
    chk("nohyst", 8'h01, ot);
    for (i = 3; i < 6; i = i + 1) begin
      wr(8'h0a, i[7:0]);
      rdc("rate", 8'h04, 8'hff, i[7:0]);
      cnt(512);
      x = 512 / (IMAX >> i);
      chk("ratecnt", 8'h01, (c >= x - 1 && c <= x + 1));
    end
    wr(8'h0a, 8'h08);
    wr(8'h09, 8'h44);
    rdc("setup", 8'h03, 8'hff, 8'h44);
    chk("range", 8'h01, range_ext_o);
    cnt(20);
    cnt(200);
    chk("sdstop", 8'h00, c);
    rs = xs(rs);
    wr(8'h0f, rs[7:0]);
    cnt(200);
    chk("oneshot", 8'h01, c);
    for (i = 0; i < 4; i = i + 1) begin
      rs = xs(rs);
      wr(8'h0b + i[0], rs[7:0]);
      rdc("bound", 8'h05 + i[0], 8'hff, rs[7:0]);
    end
    wr(8'h09, 8'h5f);
    rdc("rsvd", 8'h03, 8'hff, 8'h44);
    wr(8'h09, 8'h00);
    cnt(200);
    chk("resume", 8'h01, c > 0);
    results;
  end
endmodule // test_temp_monitor_status_alert_cfg
